//--- logic/stop_ctl.v
// Purpose: stop state selection, clock/regulator gating, debug in stop
// Assumes: wake and debug command inputs arrive from other domains
// Notes:   apb slave with sticky write-one-to-clear interrupt status
//
// What this block does
// - halted debug entry only with debug enable
// - debug clock kept running in stop if enabled
// - regulator stays full when debug enabled
// - deep stop becomes retaining stop under debug
// - stopped: refuse commands, mem-status returns error
// - halt command in stop wakes into debug
// - halted debug accepts all commands
// - low-voltage detector raises interrupt or reset
// - lvd in stop keeps regulator active
// - deep stop becomes retaining stop under lvd
// - clock source optionally runs in retaining stop
// - peripheral clocks gated in any stop
// - peripheral clocks gated even with debug
// - converter runs in stop only with async clock and lvd
// - deep stop needs select and stop enable
// - stop while disabled forces illegal-opcode reset
// - retaining stop exits on reset pin or interrupts
`timescale 1ns/1ps
`include "stop_ctl_defines.vh"

module stop_ctl (
	// clock and reset
	input  wire        clk_sys,
	input  wire        arst_n,
	// apb
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// core
	input  wire        stop_exec,
	input  wire        reset_pin_n,
	input  wire        wake_timer_irq,
	input  wire        lvd_trip,
	input  wire        conv_irq,
	input  wire        ext_irq,
	input  wire        kbd_irq,
	input  wire        lvd_reset_sel,
	// debug host commands
	input  wire        dbg_cmd_valid,
	input  wire [1:0]  dbg_cmd,
	output reg         dbg_resp_valid,
	output reg  [1:0]  dbg_resp,
	// power and clock controls
	output reg         periph_clk_en,
	output reg         debug_clk_en,
	output reg         regulator_full,
	output reg         ics_run,
	output reg         conv_run,
	output reg         pin_latch,
	output reg         halted_debug,
	output reg         illegal_reset,
	output reg         lvd_reset,
	output reg         irq
);

////////////////////////////////////////////////////////////////////////////
reg         rst_s1_reg;
reg         rst_reg;

always @(posedge clk_sys or negedge arst_n) begin
	if (!arst_n) begin
		rst_s1_reg <= 1'b0;
		rst_reg    <= 1'b0;
	end else begin
		rst_s1_reg <= 1'b1;
		rst_reg    <= rst_s1_reg;
	end
end

////////////////////////////////////////////////////////////////////////////
// two-flop synchronisers for external inputs
localparam SYN_W = 10;
wire [SYN_W-1:0] syn_in;
reg  [SYN_W-1:0] syn1_reg;
reg  [SYN_W-1:0] syn2_reg;

assign syn_in = {dbg_cmd, dbg_cmd_valid, lvd_reset_sel, kbd_irq, ext_irq,
	conv_irq, lvd_trip, wake_timer_irq, reset_pin_n};

always @(posedge clk_sys or negedge rst_reg) begin
	if (!rst_reg) begin
		// idle levels, so the reset pin does not look asserted after reset
		syn1_reg <= `SYNC_IDLE;
		syn2_reg <= `SYNC_IDLE;
	end else begin
		syn1_reg <= syn_in;
		syn2_reg <= syn1_reg;
	end
end

wire       pin_rst_n  = syn2_reg[0];
wire       wake_timer = syn2_reg[1];
wire       lvd_s      = syn2_reg[2];
wire       conv_s     = syn2_reg[3];
wire       ext_s      = syn2_reg[4];
wire       kbd_s      = syn2_reg[5];
wire       lvd_rsel   = syn2_reg[6];
wire       cmd_lvl    = syn2_reg[7];
wire [1:0] cmd_s      = syn2_reg[9:8];

reg        cmd_lvl_d_reg;
wire       cmd_pulse = cmd_lvl & ~cmd_lvl_d_reg;

////////////////////////////////////////////////////////////////////////////
// registers
reg  [`CTRL_W-1:0] ctrl_reg;
reg  [`IRQ_W-1:0]  irq_stat_reg;
reg  [`IRQ_W-1:0]  irq_mask_reg;
reg  [1:0]         state_reg;
reg                deep_flag_reg;
reg                dbg_keep_reg;
reg  [`IRQ_W-1:0]  irq_set;

wire dbg_en   = ctrl_reg[`BIT_DEBUG_ENTRY];
wire lvd_stop = ctrl_reg[`BIT_LVD_EN] & ctrl_reg[`BIT_LVD_STOP_EN];
wire wr_acc   = psel & penable & pwrite;
wire ack_wr   = wr_acc & (paddr == `OFF_CTRL) & pwdata[`BIT_DEEP_ACK];

// a lvd interrupt is only raised when reset was not chosen
wire lvd_irq  = lvd_s & ~lvd_rsel;
wire wake_any = ~pin_rst_n | wake_timer | lvd_irq | conv_s | ext_s
	| kbd_s;
wire deep_wake = ~pin_rst_n | wake_timer | ext_s;
wire halt_cmd = cmd_pulse & (cmd_s == `CMD_HALT);

////////////////////////////////////////////////////////////////////////////
// stop state machine
reg  [1:0] state_next;
reg        illegal_next;

always @* begin
	state_next   = state_reg;
	illegal_next = 1'b0;
	irq_set      = {`IRQ_W{1'b0}};
	irq_set[`IRQ_LVD] = lvd_irq;
	case (state_reg)
	`ST_RUN: begin
		if (halt_cmd && dbg_en)
			state_next = `ST_HALTED;
		else if (stop_exec) begin
			if (!ctrl_reg[`BIT_STOP_EN])
				illegal_next = 1'b1;
			else begin
				irq_set[`IRQ_STOP_ENTRY] = 1'b1;
				// select evaluated at the stop instruction
				if (ctrl_reg[`BIT_DEEP_SEL] && !dbg_en && !lvd_stop)
					state_next = `ST_DEEP;
				else
					state_next = `ST_RETAIN;
			end
		end
	end
	`ST_RETAIN: begin
		if (halt_cmd && dbg_keep_reg) begin
			state_next = `ST_HALTED;
			irq_set[`IRQ_WAKE] = 1'b1;
		end else if (wake_any) begin
			state_next = `ST_RUN;
			irq_set[`IRQ_WAKE] = 1'b1;
		end
	end
	`ST_DEEP: begin
		if (deep_wake) begin
			state_next = `ST_RUN;
			irq_set[`IRQ_WAKE] = 1'b1;
		end
	end
	`ST_HALTED: begin
		// leave debug only on the other command (code 3), and only while debug entry is disabled
		if (cmd_pulse && cmd_s == `CMD_OTHER && !dbg_en)
			state_next = `ST_RUN;
	end
	default: state_next = `ST_RUN;
	endcase
	if (illegal_next)
		irq_set[`IRQ_ILLEGAL] = 1'b1;
end

wire stopped_next = (state_next == `ST_RETAIN) || (state_next == `ST_DEEP);

always @(posedge clk_sys or negedge rst_reg) begin
	if (!rst_reg) begin
		state_reg      <= `ST_RUN;
		dbg_keep_reg   <= 1'b0;
		deep_flag_reg  <= 1'b0;
		cmd_lvl_d_reg  <= 1'b0;
		periph_clk_en  <= 1'b1;
		debug_clk_en   <= 1'b1;
		regulator_full <= 1'b1;
		ics_run        <= 1'b1;
		conv_run       <= 1'b1;
		pin_latch      <= 1'b0;
		halted_debug   <= 1'b0;
		illegal_reset  <= 1'b0;
		lvd_reset      <= 1'b0;
		dbg_resp_valid <= 1'b0;
		dbg_resp       <= `RESP_OK;
	end else begin
		state_reg     <= state_next;
		cmd_lvl_d_reg <= cmd_lvl;
		if (state_reg == `ST_RUN && stop_exec)
			dbg_keep_reg <= dbg_en;
		if (state_reg == `ST_DEEP && state_next == `ST_RUN)
			deep_flag_reg <= 1'b1;
		else if (ack_wr)
			deep_flag_reg <= 1'b0;
		illegal_reset <= illegal_next;
		lvd_reset     <= lvd_s & lvd_rsel;
		periph_clk_en <= ~stopped_next;
		// stop outputs are chosen once, at entry, and held while stopped,
		// so settings written during stop or left from an earlier stop
		// cannot change them
		if (stopped_next && state_reg == `ST_RUN) begin
			debug_clk_en <= dbg_en;
			regulator_full <= (state_next == `ST_RETAIN) &&
				(dbg_en || lvd_stop);
			// the clock source stays active while debug is kept alive
			ics_run <= (state_next == `ST_RETAIN) &&
				(ctrl_reg[`BIT_ICS_STOP_EN] || dbg_en);
			conv_run <= (state_next == `ST_RETAIN) &&
				ctrl_reg[`BIT_ADC_ASYNC] && lvd_stop;
		end else if (!stopped_next) begin
			debug_clk_en   <= 1'b1;
			regulator_full <= 1'b1;
			ics_run        <= 1'b1;
			conv_run       <= 1'b1;
		end
		// pins latch on deep entry, held until acknowledge
		if (state_next == `ST_DEEP)
			pin_latch <= 1'b1;
		else if (ack_wr)
			pin_latch <= 1'b0;
		halted_debug <= (state_next == `ST_HALTED);
		dbg_resp_valid <= cmd_pulse;
		if (cmd_pulse) begin
			if (state_reg == `ST_HALTED)
				dbg_resp <= `RESP_OK;
			else if (state_reg == `ST_RUN)
				dbg_resp <= (cmd_s == `CMD_OTHER) ? `RESP_REFUSED
					: `RESP_OK;
			else if (cmd_s == `CMD_MEM_STATUS)
				dbg_resp <= `RESP_STOP_ERR;
			else if (cmd_s == `CMD_HALT && dbg_keep_reg)
				dbg_resp <= `RESP_OK;
			else
				dbg_resp <= `RESP_REFUSED;
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// apb slave, zero wait states
wire        rd_acc = psel & ~penable & ~pwrite;
reg  [31:0] rd_next;

always @* begin
	case (paddr)
	`OFF_CTRL:       rd_next = {24'h000000, 1'b0, ctrl_reg[6:0]};
	`OFF_STATUS:     rd_next = {28'h0000000, pin_latch, deep_flag_reg,
		state_reg};
	`OFF_IRQ_STATUS: rd_next = {28'h0000000, irq_stat_reg};
	`OFF_IRQ_MASK:   rd_next = {28'h0000000, irq_mask_reg};
	default:         rd_next = 32'h00000000;
	endcase
end

wire mapped = (paddr == `OFF_CTRL) || (paddr == `OFF_STATUS) ||
	(paddr == `OFF_IRQ_STATUS) || (paddr == `OFF_IRQ_MASK);

always @(posedge clk_sys or negedge rst_reg) begin
	if (!rst_reg) begin
		ctrl_reg     <= `CTRL_RESET;
		irq_stat_reg <= {`IRQ_W{1'b0}};
		irq_mask_reg <= {`IRQ_W{1'b0}};
		prdata       <= 32'h00000000;
		pready       <= 1'b0;
		pslverr      <= 1'b0;
		irq          <= 1'b0;
	end else begin
		pready  <= psel & ~penable;
		pslverr <= psel & ~penable & ~mapped;
		if (rd_acc)
			prdata <= rd_next;
		if (wr_acc && paddr == `OFF_CTRL)
			ctrl_reg <= {1'b0, pwdata[6:0]};
		if (wr_acc && paddr == `OFF_IRQ_MASK)
			irq_mask_reg <= pwdata[`IRQ_W-1:0];
		// set wins over write-one-to-clear
		if (wr_acc && paddr == `OFF_IRQ_STATUS)
			irq_stat_reg <= (irq_stat_reg & ~pwdata[`IRQ_W-1:0]) | irq_set;
		else
			irq_stat_reg <= irq_stat_reg | irq_set;
		irq <= |(irq_stat_reg & irq_mask_reg);
	end
end

endmodule // stop_ctl

//--- logic/stop_ctl_defines.vh
// Purpose: constants for the low-power stop mode controller
// Assumes: apb register map, one 32-bit word per register
// Notes:   offsets are byte addresses
`ifndef STOP_CTL_DEFINES_VH
`define STOP_CTL_DEFINES_VH

`define OFF_CTRL        12'h000
`define OFF_STATUS      12'h004
`define OFF_IRQ_STATUS  12'h008
`define OFF_IRQ_MASK    12'h00c

// control register fields
`define BIT_DEBUG_ENTRY 0
`define BIT_LVD_EN      1
`define BIT_LVD_STOP_EN 2
`define BIT_DEEP_SEL    3
`define BIT_STOP_EN     4
`define BIT_ICS_STOP_EN 5
`define BIT_ADC_ASYNC   6
`define BIT_DEEP_ACK    7
`define CTRL_W          8
`define CTRL_RESET      8'h00

// status register fields
`define ST_RUN          2'h0
`define ST_RETAIN       2'h1
`define ST_DEEP         2'h2
`define ST_HALTED       2'h3

// irq status bits
`define IRQ_W           4
`define IRQ_STOP_ENTRY  0
`define IRQ_WAKE        1
`define IRQ_ILLEGAL     2
`define IRQ_LVD         3

// synchroniser idle levels: reset pin high, all other inputs low
`define SYNC_IDLE       10'h001

// debug command codes
`define CMD_HALT        2'h1
`define CMD_MEM_STATUS  2'h2
`define CMD_OTHER       2'h3
`define RESP_OK         2'h0
`define RESP_STOP_ERR   2'h1
`define RESP_REFUSED    2'h2

`endif

//--- testbench/debug_host_model.sv
// Purpose: background debug host on the command port
// Assumes: commands spaced by idle gaps
// Notes:   code held after a command
`timescale 1ns/1ps
module debug_host_model (
	// link
	input wire         clk_sys,
	input wire         dbg_resp_valid,
	input wire [1:0]   dbg_resp,
	output logic       dbg_cmd_valid,
	output logic [1:0] dbg_cmd
);
	int n;
	initial begin
		dbg_cmd_valid = 1'b0;
		dbg_cmd = 2'h3;
	end
	// halt may be sent in stop too
	task automatic send(input logic [1:0] c, input int gap,
		output logic [1:0] r);
		// code settles a cycle before valid rises, so it is stable
		// by the time the valid edge leaves the synchroniser
		@(posedge clk_sys);
		dbg_cmd <= c;
		@(posedge clk_sys);
		dbg_cmd_valid <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (dbg_resp_valid !== 1'b1 && n < 20);
		r = (n < 20) ? dbg_resp : 2'bxx;
		dbg_cmd_valid <= 1'b0;
		repeat (3 + gap) @(posedge clk_sys);
	endtask
endmodule // debug_host_model

//--- testbench/low_power_stop_mode_control_tb.sv
// Purpose: self-checking bench of the stop controller
// Assumes: debug host model on the command port
// Notes:   expected states from the selection model
`timescale 1ns/1ps
`include "stop_ctl_defines.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
	err_total++; $display("Error %0t %h %h", $time, a, e); end end
module low_power_stop_mode_control_tb;
	logic clk_sys, arst_n, psel, penable, pwrite, stop_exec, lvd_trip;
	logic ext_irq, lvd_reset_sel, pready, pslverr, dbg_cmd_valid, ia;
	logic dbg_resp_valid, periph_clk_en, debug_clk_en, regulator_full;
	logic ics_run, conv_run, pin_latch, halted_debug, illegal_reset;
	logic lvd_reset, irq, slv, dbg, deep, reg_on;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [1:0] dbg_cmd, dbg_resp, rsp;
	logic [1:0] cmds [5] = '{2, 3, 1, 3, 2};
	logic [1:0] resps [5] = '{1, 2, 0, 0, 0};
	logic [7:0] c;
	logic reset_pin_n, wake_timer_irq, conv_irq, kbd_irq;
	logic [1:0] src;
	int err_total = 0, comparisons = 0, cyc = 0, n;
	int seed = 32'h46bc;
	stop_ctl u_dut (.*);
	debug_host_model u_host (.*);
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic finish_test;
		$display("compares %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic stop_now;
		@(posedge clk_sys);
		stop_exec <= 1'b1;
		@(posedge clk_sys);
		stop_exec <= 1'b0;
		@(negedge clk_sys);
	endtask
	initial begin
		{arst_n, psel, penable, pwrite, stop_exec, lvd_trip} = 6'h0;
		{ext_irq, lvd_reset_sel, paddr, pwdata} = 46'h0;
		{reset_pin_n, wake_timer_irq, conv_irq, kbd_irq} = 4'h8;
		repeat (5) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		apb(0, `OFF_CTRL, 0);
		`CHK(r, 32'h0)
		apb(0, 12'h010, 0);
		`CHK({slv, r}, 33'h100000000)
		u_host.send(`CMD_HALT, 0, rsp);
		`CHK(halted_debug, 1'b0)
		$display("done: registers, run halt");
		for (int i = 0; i < 16; i++) begin
			c = {1'b0, 2'($random(seed)), 1'b1, 4'(i)};
			dbg = c[0];
			deep = c[3] && !dbg && !(c[1] && c[2]);
			reg_on = dbg || (c[1] && c[2]);
			apb(1, `OFF_CTRL, {24'h0, c});
			stop_now();
			`CHK({periph_clk_en, debug_clk_en}, {1'b0, dbg})
			`CHK({regulator_full, pin_latch}, {reg_on, deep})
			`CHK(ics_run, !deep && (c[5] || dbg))
			`CHK(conv_run, !deep && c[6] && c[1] && c[2])
			apb(1, `OFF_CTRL, 0);
			apb(0, `OFF_STATUS, 0);
			`CHK(r[1:0], deep ? `ST_DEEP : `ST_RETAIN)
			// random wake source; deep stop only has pin, timer, ext
			src = 2'($random(seed));
			ext_irq <= (src == 2'h0) || (src == 2'h3 && deep);
			wake_timer_irq <= (src == 2'h1);
			reset_pin_n <= (src != 2'h2);
			kbd_irq <= (src == 2'h3) && !deep && i[0];
			conv_irq <= (src == 2'h3) && !deep && !i[0];
			n = 0;
			while (periph_clk_en !== 1'b1 && n < 30) begin
				@(negedge clk_sys);
				n++;
			end
			apb(0, `OFF_STATUS, 0);
			`CHK(r[3:0], {deep, deep, 2'b00})
			{ext_irq, wake_timer_irq, kbd_irq, conv_irq} <= 4'h0;
			reset_pin_n <= 1'b1;
			apb(1, `OFF_CTRL, 32'h80);
			@(negedge clk_sys);
			`CHK(pin_latch, 1'b0)
		end
		$display("done: stop selection");
		apb(1, `OFF_CTRL, 32'h2);
		apb(1, `OFF_IRQ_STATUS, 32'hf);
		stop_now();
		`CHK({illegal_reset, periph_clk_en}, 2'b11)
		@(posedge clk_sys);
		lvd_trip <= 1'b1;
		repeat (8) @(posedge clk_sys);
		lvd_trip <= 1'b0;
		apb(0, `OFF_IRQ_STATUS, 0);
		`CHK(r, 32'hc)
		apb(1, `OFF_IRQ_MASK, 0);
		@(negedge clk_sys);
		ia = irq;
		// irq is registered from the status and mask registers
		apb(1, `OFF_IRQ_MASK, 32'hf);
		repeat (2) @(negedge clk_sys);
		`CHK(ia ^ irq, 1'b1)
		apb(1, `OFF_IRQ_STATUS, 32'hf);
		repeat (2) @(negedge clk_sys);
		`CHK(irq, 1'b0)
		@(posedge clk_sys);
		lvd_reset_sel <= 1'b1;
		lvd_trip <= 1'b1;
		repeat (8) @(posedge clk_sys);
		`CHK(lvd_reset, 1'b1)
		lvd_trip <= 1'b0;
		$display("done: interrupts");
		apb(1, `OFF_CTRL, 32'h11);
		stop_now();
		for (int i = 0; i < 5; i++) begin
			u_host.send(cmds[i], i, rsp);
			`CHK(rsp, resps[i])
		end
		`CHK(halted_debug, 1'b1)
		apb(1, `OFF_CTRL, 32'h10);
		u_host.send(`CMD_OTHER, 0, rsp);
		`CHK({rsp, halted_debug}, 3'h0)
		$display("done: debug in stop");
		finish_test();
	end
endmodule // low_power_stop_mode_control_tb

//--- testbench/stop_ctl_assertions.sv
// Purpose: port checks of the stop controller
// Assumes: one clock, reset active low
// Notes:   bound into every stop_ctl
`timescale 1ns/1ps
`include "stop_ctl_defines.vh"
module stop_ctl_assertions (
	// watched ports
	input wire       clk_sys, arst_n, stop_exec, lvd_reset_sel,
	input wire [1:0] dbg_cmd, dbg_resp,
	input wire       dbg_resp_valid, periph_clk_en, debug_clk_en,
	input wire       regulator_full, conv_run, pin_latch,
	input wire       halted_debug, illegal_reset, lvd_reset
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	property p_gate; $fell(periph_clk_en) |-> $past(stop_exec); endproperty
	a_gate: assert property (p_gate)
		else $error("gate without stop");
	property p_dbg; !debug_clk_en |-> !periph_clk_en; endproperty
	a_dbg: assert property (p_dbg)
		else $error("debug clock off outside stop");
	property p_reg; !regulator_full |-> !debug_clk_en; endproperty
	a_reg: assert property (p_reg)
		else $error("standby with debug clock");
	property p_pin;
		$rose(pin_latch) |-> !regulator_full && !periph_clk_en;
	endproperty
	a_pin: assert property (p_pin)
		else $error("pins latched outside deep stop");
	property p_conv; conv_run && !periph_clk_en |-> regulator_full; endproperty
	a_conv: assert property (p_conv)
		else $error("converter on without detector");
	property p_halt; $rose(halted_debug) |-> dbg_cmd == `CMD_HALT; endproperty
	a_halt: assert property (p_halt)
		else $error("halt without command");
	property p_mem;
		dbg_resp_valid && !periph_clk_en && !halted_debug &&
		dbg_cmd == `CMD_MEM_STATUS |-> dbg_resp == `RESP_STOP_ERR;
	endproperty
	a_mem: assert property (p_mem)
		else $error("memory access in stop");
	property p_ok;
		dbg_resp_valid && $past(halted_debug, 5) |-> dbg_resp == `RESP_OK;
	endproperty
	a_ok: assert property (p_ok)
		else $error("command refused while halted");
	property p_ill;
		$rose(illegal_reset) |-> $past(stop_exec) && periph_clk_en;
	endproperty
	a_ill: assert property (p_ill)
		else $error("bad illegal reset");
	property p_lvd; $rose(lvd_reset) |-> lvd_reset_sel; endproperty
	a_lvd: assert property (p_lvd)
		else $error("detector reset not selected");
endmodule // stop_ctl_assertions
bind stop_ctl stop_ctl_assertions u_chk (.*);
